// *** src/adcofe_pkg.sv ***
package adcofe_pkg;
   localparam int        DATA_W        = 8;
   localparam int        LATENCY       = 7;
   localparam int        INIT_CYCLES   = 20;
   localparam int        FIFO_DEPTH    = 8;
   localparam int        CLK_PERIOD_NS = 25;
   localparam int        MIN_RATE_KSPS = 1000;
   localparam logic [7:0] MSB_FLIP     = 8'h80;
   localparam logic [7:0] CODE_ZERO    = 8'h00;
endpackage : adcofe_pkg

// *** src/adcofe_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface adcofe_if;
   logic       format_select;   // High: two's complement
   logic       oe_n;            // Active-low output enable
   logic [7:0] data_out;        // Device drive value
   logic [7:0] data_oe;         // Per-bit drive enable
   logic [7:0] data_bus;        // Resolved bus level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         data_bus[i] = data_oe[i] ? data_out[i] : 1'b1;
      end
   end
   modport device (input format_select, input oe_n, output data_out, output data_oe);
   modport capture (output format_select, output oe_n, input data_bus);
endinterface : adcofe_if
`default_nettype wire

// *** src/adcofe_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcofe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk_i,  // Clock
   input  wire logic             arst_n_i,   // Async reset, low
   input  wire logic             in_valid_i, // Write request
   output logic                  in_ready_o, // Not full
   input  wire logic [WIDTH-1:0] in_data_i,  // Write data
   output logic                  out_valid_o,// Not empty
   input  wire logic             out_ready_i,// Reader accepts
   output logic      [WIDTH-1:0] out_data_o  // Read data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             do_wr, do_rd;
   always_comb begin
      in_ready_o  = (count != (AW+1)'(DEPTH));
      out_valid_o = (count != '0);
      out_data_o  = mem[rd_ptr];
      do_wr       = in_valid_i && in_ready_o;
      do_rd       = out_valid_o && out_ready_i;
      next_wr_ptr = do_wr ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = do_rd ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count  = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule : adcofe_fifo
`default_nettype wire

// *** src/adcofe_device.sv ***
// Overview of operation
// - Format low gives offset binary output
// - Format high gives two's complement output
// - Codings differ only in the msb
// - Enable high floats all data outputs
// - Capture holds enable low normally
// - First 20 clocks invalid; capture discards
// - Sample clock must exceed 1 MSPS
// - Clock duty cycle within 50 +/- 5 percent
// - Word appears seven clocks after sample
// - Sample on falling edge, update on rising
`timescale 1ns/1ps
`default_nettype none
module adcofe_device #(
   parameter int LATENCY     = adcofe_pkg::LATENCY,
   parameter int INIT_CYCLES = adcofe_pkg::INIT_CYCLES
) (
   input  wire logic       sys_clk_i,     // Sample clock
   input  wire logic       arst_n_i,      // Async reset, low
   input  wire logic [7:0] sample_i,      // Converted sample, offset binary
   adcofe_if.device        bus,           // Pin side
   output logic            data_valid_o   // Init period over
);
   // Control pins in the synchroniser vector
   localparam int SYNC_N   = 2;
   localparam int SYNC_FMT = 0;
   localparam int SYNC_OE  = 1;

   // Format resets to offset binary, enable to floating
   localparam logic [SYNC_N-1:0] SYNC_RST = 2'h2;

   // The output register is the last clock of latency
   localparam int STAGES = LATENCY - 1;

   localparam int CNT_W  = $clog2(INIT_CYCLES + 1);

   localparam logic [7:0] DRIVE_NONE = 8'h00;
   localparam logic [7:0] DRIVE_ALL  = 8'hFF;

   // Initialisation phases after reset
   typedef enum logic {
      INIT_WAIT,
      INIT_DONE
   } adcofe_init_state_type;

   logic [SYNC_N-1:0]     pin_raw;
   logic [SYNC_N-1:0]     ctrl_q;

   logic [7:0]            sample_neg;
   logic [7:0]            next_sample_neg;
   logic [7:0]            tap [STAGES+1];

   logic [7:0]            out_word;
   logic [7:0]            next_out_word;

   adcofe_init_state_type init_state;
   adcofe_init_state_type next_init_state;
   logic [CNT_W-1:0]      init_cnt;
   logic [CNT_W-1:0]      next_init_cnt;

   // Input words are offset binary; the other coding only flips the msb
   function automatic logic [7:0] code_word(
      input logic [7:0] offset_word,
      input logic       twos
   );
      logic [7:0] flip;
      flip = twos ? adcofe_pkg::MSB_FLIP : adcofe_pkg::CODE_ZERO;
      return offset_word ^ flip;
   endfunction : code_word

   // Raw control pins, one bit each
   assign pin_raw[SYNC_FMT] = bus.format_select;
   assign pin_raw[SYNC_OE]  = bus.oe_n;

   // Pins are not timed to the sample clock: three stages per pin
   for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
      logic stage1;
      logic stage2;
      logic stage3;
      logic held;
      logic next_stage1;
      logic next_stage2;
      logic next_stage3;
      logic next_held;

      // A pin caught mid-change is ignored until the last two stages agree
      always_comb begin
         next_stage1 = pin_raw[g];
         next_stage2 = stage1;
         next_stage3 = stage2;
         next_held   = (stage2 == stage3) ? stage3 : held;
      end

      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            stage1 <= SYNC_RST[g];
            stage2 <= SYNC_RST[g];
            stage3 <= SYNC_RST[g];
            held   <= SYNC_RST[g];
         end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
            held   <= next_held;
         end
      end

      assign ctrl_q[g] = held;
   end : g_sync

   // Analog sample is taken on the falling edge
   always_comb begin
      next_sample_neg = sample_i;
   end

   always_ff @(negedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sample_neg <= adcofe_pkg::CODE_ZERO;
      end else begin
         sample_neg <= next_sample_neg;
      end
   end

   assign tap[0] = sample_neg;

   // One delay stage per clock of latency, bar the output register
   for (genvar s = 0; s < STAGES; s++) begin : g_stage
      logic [7:0] word;
      logic [7:0] next_word;

      always_comb begin
         next_word = tap[s];
      end

      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            word <= adcofe_pkg::CODE_ZERO;
         end else begin
            word <= next_word;
         end
      end

      assign tap[s+1] = word;
   end : g_stage

   // Coding applied at the output, so a format change shows five clocks after the pin, not after the pipeline latency
   always_comb begin
      next_out_word = code_word(tap[STAGES], ctrl_q[SYNC_FMT]);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_word <= adcofe_pkg::CODE_ZERO;
      end else begin
         out_word <= next_out_word;
      end
   end

   // Power-up initialisation; words before it ends are not to be trusted
   always_comb begin
      next_init_state = init_state;
      case (init_state)
         INIT_WAIT: begin
            if (init_cnt == CNT_W'(INIT_CYCLES - 1)) begin
               next_init_state = INIT_DONE;
            end
         end
         INIT_DONE: begin
            next_init_state = INIT_DONE;
         end
         default: begin
            next_init_state = INIT_WAIT;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_state <= INIT_WAIT;
      end else begin
         init_state <= next_init_state;
      end
   end

   // Counter stops once done; only a reset restarts initialisation
   always_comb begin
      next_init_cnt = init_cnt;
      if (init_state == INIT_WAIT) begin
         next_init_cnt = init_cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_cnt <= '0;
      end else begin
         init_cnt <= next_init_cnt;
      end
   end

   // Floated bits are released to the bus pull-up
   assign bus.data_out = out_word;
   assign bus.data_oe  = ctrl_q[SYNC_OE] ? DRIVE_NONE : DRIVE_ALL;
   assign data_valid_o = (init_state == INIT_DONE);
endmodule : adcofe_device
`default_nettype wire

// *** src/adcofe_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcofe_capture #(
   parameter int INIT_CYCLES = adcofe_pkg::INIT_CYCLES,
   parameter int DEPTH       = adcofe_pkg::FIFO_DEPTH
) (
   input  wire logic       sys_clk_i,       // Sample clock
   input  wire logic       arst_n_i,        // Async reset, low
   input  wire logic       format_twos_i,   // Wanted coding
   input  wire logic       enable_i,        // Drive bus when high
   adcofe_if.capture       bus,             // Pin side
   output logic            word_valid_o,    // FIFO not empty
   input  wire logic       word_ready_i,    // Consumer accepts
   output logic      [7:0] word_o,          // Captured word
   output logic            overflow_o       // Word dropped, full
);
   logic [7:0] cap, next_cap;
   logic       cap_v, next_cap_v, in_ready;
   localparam int CNT_W = $clog2(INIT_CYCLES + 1);
   logic [CNT_W-1:0] wait_cnt, next_wait_cnt;
   logic       ovf, next_ovf;

   assign bus.format_select = format_twos_i;
   assign bus.oe_n          = !enable_i;

   always_comb begin
      next_wait_cnt = (wait_cnt == CNT_W'(INIT_CYCLES)) ? wait_cnt : wait_cnt + CNT_W'(1);
      next_cap      = bus.data_bus;
      next_cap_v    = enable_i && (wait_cnt == CNT_W'(INIT_CYCLES));
      next_ovf      = ovf || (cap_v && !in_ready);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cap      <= 8'h00;
         cap_v    <= 1'b0;
         wait_cnt <= '0;
         ovf      <= 1'b0;
      end else begin
         cap      <= next_cap;
         cap_v    <= next_cap_v;
         wait_cnt <= next_wait_cnt;
         ovf      <= next_ovf;
      end
   end

   assign overflow_o = ovf;

   adcofe_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (cap_v),
      .in_ready_o  (in_ready),
      .in_data_i   (cap),
      .out_valid_o (word_valid_o),
      .out_ready_i (word_ready_i),
      .out_data_o  (word_o)
   );
endmodule : adcofe_capture
`default_nettype wire

// *** verification/adcofe_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcofe_properties (
   input wire logic       sys_clk_i,     // Clock
   input wire logic       arst_n_i,      // Async reset, low
   input wire logic [7:0] sample_i,      // Device sample
   input wire logic       format_select, // Coding select
   input wire logic       oe_n,          // Enable, low
   input wire logic [7:0] data_out,      // Device value
   input wire logic [7:0] data_oe,       // Drive enables
   input wire logic [7:0] data_bus       // Bus level
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   chk_float_idle: assert property (oe_n [*5] |-> data_oe == 8'h00)
      else $error("bus driven while disabled");
   chk_drive_on: assert property (!oe_n [*5] |-> data_oe == 8'hFF)
      else $error("bus not driven while enabled");
   chk_float_lag: assert property ($rose(oe_n) |-> ##[1:5] data_oe == 8'h00)
      else $error("bus slow to float");
   chk_drive_lag: assert property ($fell(oe_n) |-> ##[1:5] data_oe == 8'hFF)
      else $error("bus slow to drive");
   chk_oe_uniform: assert property (data_oe == 8'h00 || data_oe == 8'hFF)
      else $error("bus bits enabled unevenly");
   chk_float_level: assert property (data_oe == 8'h00 |-> data_bus == 8'hFF)
      else $error("floating bus not at pull level");
   chk_offset_code: assert property (!format_select [*8] ##1 !format_select [*6]
      |-> data_out == $past(sample_i, 7)) else $error("offset word wrong");
   chk_twos_code: assert property (format_select [*8] ##1 format_select [*6]
      |-> data_out == ($past(sample_i, 7) ^ 8'h80)) else $error("twos word wrong");
endmodule : adcofe_properties
`default_nettype wire

// *** verification/adc_output_format_enable_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_enable_test;
   logic       clk;
   logic       arst_n;
   logic [7:0] sample;
   logic       twos;
   logic       enable;
   logic       ready;
   logic       valid;
   logic [7:0] word;
   logic       overflow;
   logic       dev_valid;
   int         error_cnt;
   int         checks_done;
   logic [7:0] vals [4] = '{8'hFF, 8'h00, 8'h80, 8'h7F};
   adcofe_if bus ();
   adcofe_device adcofe_device_inst (.sys_clk_i(clk), .arst_n_i(arst_n), .sample_i(sample), .bus(bus.device),
      .data_valid_o(dev_valid));
   adcofe_capture adcofe_capture_inst (.sys_clk_i(clk), .arst_n_i(arst_n), .format_twos_i(twos), .enable_i(enable),
      .bus(bus.capture), .word_valid_o(valid), .word_ready_i(ready), .word_o(word), .overflow_o(overflow));
   adcofe_properties adcofe_properties_inst (.sys_clk_i(clk), .arst_n_i(arst_n), .sample_i(sample),
      .format_select(bus.format_select), .oe_n(bus.oe_n), .data_out(bus.data_out), .data_oe(bus.data_oe),
      .data_bus(bus.data_bus));
   initial begin
      clk = 1'b0;
      forever #(adcofe_pkg::CLK_PERIOD_NS / 2.0) clk = ~clk;
   end
   task automatic print_verdict();
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Drain with consumer ready, then stall three clocks so fresh words wait in the fifo
   task automatic flush(input int n);
      ready <= 1'b1;
      repeat (n) @(posedge clk);
      ready <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : flush
   task automatic read_word(input logic [7:0] exp);
      int i;
      for (i = 0; i < 50 && valid !== 1'b1; i++) @(negedge clk);
      if (i == 50) begin
         error_cnt++;
         print_verdict();
      end
      cmp(word, exp);
      @(posedge clk);
   endtask : read_word
   initial begin
      arst_n = 1'b0;
      sample = 8'h00;
      twos = 1'b0;
      enable = 1'b0;
      ready = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (10) @(posedge clk);
      @(negedge clk);
      cmp({7'h00, dev_valid}, 8'h00);
      repeat (20) @(posedge clk);
      @(negedge clk);
      cmp(bus.data_bus, 8'hFF);
      cmp({7'h00, valid}, 8'h00);
      cmp({7'h00, dev_valid}, 8'h01);
      @(posedge clk);
      enable <= 1'b1;
      foreach (vals[i]) for (int f = 0; f < 2; f++) begin
         sample <= vals[i];
         twos <= f[0];
         flush(30);
         @(negedge clk);
         cmp(bus.data_bus, vals[i] ^ {f[0], 7'h00});
         read_word(vals[i] ^ {f[0], 7'h00});
      end
      cmp({7'h00, overflow}, 8'h01);
      enable <= 1'b0;
      flush(30);
      @(negedge clk);
      cmp(bus.data_bus, 8'hFF);
      cmp({7'h00, valid}, 8'h00);
      print_verdict();
   end
endmodule : adc_output_format_enable_test
`default_nettype wire
